// ---- core/sfg_guard.sv ----
// Sector unlock guard and power-up write inhibit of a serial flash.
// Assumes REF_CLK_IN at 50 MHz, SPI host on SCK_IN, block protect bits
// supplied by the status register on the reference clock.
`timescale 1ns/10ps
module sfg_guard #(
  parameter int unsigned PUW_CYCLES = sfg_pkg::PUW_CYCLES // Delay length
) (
  input wire logic REF_CLK_IN, // Reference clock
  input wire logic RST_N_IN, // Power-on reset
  input wire logic SCK_IN, // Serial clock pin
  input wire logic CS_N_IN, // Chip select pin
  input wire logic SI_IN, // Serial data pin
  input wire logic VCC_LOW_IN, // Supply under write-inhibit level
  input wire logic [3:0] BLOCK_PROTECT_IN, // Block protect bits 3..0
  input wire logic [sfg_pkg::ADDR_W-1:0] CHECK_ADDR_IN, // Address to check
  output logic READY_OUT, // Power-up delay over
  output logic WRITE_INHIBIT_OUT, // Writes disabled by low supply
  output logic WRITE_ENABLE_LATCH_OUT, // Write enable latch
  output logic SECTOR_OPEN_OUT, // One sector is open
  output logic [sfg_pkg::SECTOR_W-1:0] OPEN_SECTOR_OUT, // Open sector number
  output logic PGM_ALLOWED_OUT // Program/erase allowed at check address
);

  // ****************************************
  // Constants
  // ****************************************
  localparam int unsigned PUW_LAST_I = PUW_CYCLES - 1; // Last count
  localparam logic [sfg_pkg::PUW_CNT_W-1:0] PUW_LAST =
    PUW_LAST_I[sfg_pkg::PUW_CNT_W-1:0];

  // ****************************************
  // Declarations
  // ****************************************
  sfg_pkg::sfg_state_t st; // Registered state
  sfg_pkg::sfg_state_t next_st; // Next state
  logic [sfg_pkg::BIT_CNT_W-1:0] link_cnt; // Clocks of last frame
  logic [sfg_pkg::FRAME_W-1:0] link_shift; // Bits of last frame
  logic cs_rise; // Frame just ended
  logic ready; // Standby reached
  logic inhibit; // Supply low
  logic short_frame; // Exactly one byte
  logic long_frame; // Exactly four bytes
  logic [7:0] short_opc; // Opcode of a one-byte frame
  logic [7:0] long_opc; // Opcode of a four-byte frame
  logic [sfg_pkg::ADDR_W-1:0] frame_addr; // Address of a four-byte frame
  logic do_wren; // Accepted write enable
  logic do_close; // Accepted close
  logic open_req; // Well-formed open frame
  logic do_open; // Accepted open
  logic check_hit; // Check address in open sector

  // Protection of a block by the block protect code; top blocks first
  function automatic logic blk_prot(input logic [3:0] bp,
                                    input logic [sfg_pkg::BLOCK_W-1:0] blk);
    logic [6:0] span;
    span = 7'h01 << (bp - 4'h1);
    if (bp == 4'h0)
    begin
      return 1'b0;
    end
    if (bp >= sfg_pkg::BP_ALL)
    begin
      return 1'b1;
    end
    return {1'b0, blk} >= (sfg_pkg::BLOCK_COUNT - span);
  endfunction

  // ****************************************
  // Link side capture
  // ****************************************
  sfg_link u_link (
    .sck_in(SCK_IN),
    .rst_n_in(RST_N_IN),
    .cs_n_in(CS_N_IN),
    .si_in(SI_IN),
    .bit_cnt_out(link_cnt),
    .shift_out(link_shift)
  );

  // ****************************************
  // Frame decode
  // ****************************************
  // Link words are read only at the synchronised select rise, when the
  // serial clock has stopped and they stand still
  always_comb
  begin
    cs_rise = st.cs_s2 & ~st.cs_s3;
    ready = (st.pwr == sfg_pkg::SFG_PWR_STANDBY);
    inhibit = st.low_s2;
    short_frame = (link_cnt == sfg_pkg::SHORT_FRAME_BITS);
    long_frame = (link_cnt == sfg_pkg::OPEN_FRAME_BITS);
    short_opc = link_shift[7:0];
    long_opc = link_shift[sfg_pkg::FRAME_W-1:sfg_pkg::ADDR_W];
    frame_addr = link_shift[sfg_pkg::ADDR_W-1:0];
    // Nothing is taken before the power-up delay has run out
    do_wren = cs_rise && ready && !inhibit && short_frame &&
              (short_opc == sfg_pkg::OPC_WRITE_ENABLE);
    do_close = cs_rise && ready && short_frame &&
               (short_opc == sfg_pkg::OPC_SECTOR_CLOSE);
    open_req = cs_rise && ready && long_frame &&
               (long_opc == sfg_pkg::OPC_SECTOR_OPEN);
    // Needs the latch, a protected block and no sector already open
    do_open = open_req && !inhibit && st.write_enable_latch &&
              !st.sector_open &&
              blk_prot(BLOCK_PROTECT_IN,
                       frame_addr[sfg_pkg::BLOCK_MSB:sfg_pkg::BLOCK_LSB]);
    check_hit = st.sector_open &&
                (CHECK_ADDR_IN[sfg_pkg::BLOCK_MSB:sfg_pkg::SECTOR_LSB] ==
                 st.open_sector);
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    next_st = st;
    // Pin synchronisers
    next_st.cs_s1 = CS_N_IN;
    next_st.cs_s2 = st.cs_s1;
    next_st.cs_s3 = st.cs_s2;
    next_st.low_s1 = VCC_LOW_IN;
    next_st.low_s2 = st.low_s1;
    // Power-up delay
    case (st.pwr)
      sfg_pkg::SFG_PWR_WAIT:
      begin
        if (st.puw_cnt >= PUW_LAST)
        begin
          next_st.pwr = sfg_pkg::SFG_PWR_STANDBY;
        end
        else
        begin
          next_st.puw_cnt = st.puw_cnt + sfg_pkg::PUW_CNT_W'(1);
        end
      end
      sfg_pkg::SFG_PWR_STANDBY:
      begin
        next_st.pwr = sfg_pkg::SFG_PWR_STANDBY;
      end
      default:
      begin
        next_st.pwr = sfg_pkg::SFG_PWR_WAIT;
      end
    endcase
    // Write enable latch
    if (do_wren)
    begin
      next_st.write_enable_latch = 1'b1;
    end
    if (do_open || inhibit)
    begin
      next_st.write_enable_latch = 1'b0;
    end
    // Open sector; only sector bits of the address are kept
    if (do_close)
    begin
      next_st.sector_open = 1'b0;
    end
    else if (do_open)
    begin
      next_st.sector_open = 1'b1;
      next_st.open_sector =
        frame_addr[sfg_pkg::BLOCK_MSB:sfg_pkg::SECTOR_LSB];
    end
    // Program/erase permission at the check address
    next_st.pgm_allowed = ready && !inhibit &&
      (!blk_prot(BLOCK_PROTECT_IN,
                 CHECK_ADDR_IN[sfg_pkg::BLOCK_MSB:sfg_pkg::BLOCK_LSB]) ||
       check_hit);
  end

  // ****************************************
  // Registers
  // ****************************************
  // Reset leaves standby pending, latch clear, nothing open
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      st <= '0;
      st.pwr <= sfg_pkg::SFG_PWR_WAIT;
      st.cs_s1 <= 1'b1;
      st.cs_s2 <= 1'b1;
      st.cs_s3 <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign READY_OUT = ready;
  assign WRITE_INHIBIT_OUT = st.low_s2;
  assign WRITE_ENABLE_LATCH_OUT = st.write_enable_latch;
  assign SECTOR_OPEN_OUT = st.sector_open;
  assign OPEN_SECTOR_OUT = st.open_sector;
  assign PGM_ALLOWED_OUT = st.pgm_allowed;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge REF_CLK_IN);
  endclocking
  default disable iff (!RST_N_IN);

  // Frame end with the open opcode and all conditions met
  sequence s_good_open;
    open_req && !inhibit && st.write_enable_latch && !st.sector_open &&
    blk_prot(BLOCK_PROTECT_IN, frame_addr[21:16]);
  endsequence

  // Frame end with a mis-counted clock total
  sequence s_bad_count;
    cs_rise && (link_cnt != 6'h20) && !st.sector_open;
  endsequence

  property p_open_takes;
    s_good_open |=> st.sector_open && (st.open_sector == $past(frame_addr[21:12]))
      && !st.write_enable_latch;
  endproperty
  a_open_takes: assert property (p_open_takes)
    else $error("open frame did not open the addressed sector");

  property p_bad_count;
    s_bad_count |=> !st.sector_open;
  endproperty
  a_bad_count: assert property (p_bad_count)
    else $error("mis-counted frame opened a sector");

  property p_unprot_block;
    open_req && !blk_prot(BLOCK_PROTECT_IN, frame_addr[21:16]) && !st.sector_open
      |=> !st.sector_open;
  endproperty
  a_unprot_block: assert property (p_unprot_block)
    else $error("sector opened in an unprotected block");

  property p_one_sector;
    st.sector_open && !do_close |=> st.sector_open && $stable(st.open_sector);
  endproperty
  a_one_sector: assert property (p_one_sector)
    else $error("open sector changed without a close");

  property p_close;
    do_close |=> !st.sector_open ##1 !st.sector_open;
  endproperty
  a_close: assert property (p_close)
    else $error("close did not revoke the open sector");

  property p_wait_quiet;
    !ready |=> !st.write_enable_latch && !st.sector_open;
  endproperty
  a_wait_quiet: assert property (p_wait_quiet)
    else $error("instruction taken before power-up delay");

  property p_wait_length;
    !ready && (st.puw_cnt < PUW_LAST) |=> !ready;
  endproperty
  a_wait_length: assert property (p_wait_length)
    else $error("standby reached before the power-up delay");

  property p_standby_entry;
    $rose(ready) |-> !st.write_enable_latch && $past(st.puw_cnt) == PUW_LAST;
  endproperty
  a_standby_entry: assert property (p_standby_entry)
    else $error("standby entered early or with latch set");

  property p_inhibit;
    inhibit |=> !st.write_enable_latch && !st.pgm_allowed;
  endproperty
  a_inhibit: assert property (p_inhibit)
    else $error("write path active under low supply");

  property p_allowed_src;
    st.pgm_allowed |-> $past(ready) && ($past(check_hit) ||
      !$past(blk_prot(BLOCK_PROTECT_IN, CHECK_ADDR_IN[21:16])));
  endproperty
  a_allowed_src: assert property (p_allowed_src)
    else $error("program allowed in a read-only sector");

endmodule // sfg_guard

// ---- core/sfg_link.sv ----
// Serial capture on the host's clock: counts clocks and shifts in bits.
// Assumes SPI mode 0/3 (sample on rising edge) and no clock with select high.
`timescale 1ns/10ps
module sfg_link (
  input wire logic sck_in, // Serial clock from host
  input wire logic rst_n_in, // Power-on reset
  input wire logic cs_n_in, // Chip select pin
  input wire logic si_in, // Serial data in
  output logic [sfg_pkg::BIT_CNT_W-1:0] bit_cnt_out, // Clocks in last frame
  output logic [sfg_pkg::FRAME_W-1:0] shift_out // Bits of last frame
);

  // ****************************************
  // State
  // ****************************************
  sfg_pkg::sfg_link_t st; // Registered state
  sfg_pkg::sfg_link_t next_st; // Next state
  logic fresh; // First clock of a frame is due

  // Armed while select is high, since the clock stands still then
  always_ff @(posedge sck_in or posedge cs_n_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      fresh <= 1'b1; // Reset leaves it armed, never unknown
    end
    else if (cs_n_in)
    begin
      fresh <= 1'b1;
    end
    else
    begin
      fresh <= 1'b0;
    end
  end

  // Count and shift; restart on the first clock of each frame
  always_comb
  begin
    next_st = st;
    if (fresh)
    begin
      next_st.bit_cnt = sfg_pkg::BIT_CNT_W'(1);
      next_st.shift = {{(sfg_pkg::FRAME_W-1){1'b0}}, si_in};
    end
    else
    begin
      if (st.bit_cnt != sfg_pkg::BIT_CNT_MAX)
      begin
        next_st.bit_cnt = st.bit_cnt + sfg_pkg::BIT_CNT_W'(1);
      end
      next_st.shift = {st.shift[sfg_pkg::FRAME_W-2:0], si_in};
    end
  end

  // Link registers; they hold still between frames
  always_ff @(posedge sck_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign bit_cnt_out = st.bit_cnt;
  assign shift_out = st.shift;

endmodule // sfg_link

// ---- core/sfg_pkg.sv ----
// Shared constants and types of the sector unlock guard.
// Assumes a 50 MHz reference clock and an SPI host in mode 0 or 3.
package sfg_pkg;

  // ****************************************
  // Instruction codes
  // ****************************************
  localparam logic [7:0] OPC_WRITE_ENABLE = 8'h06; // Sets the write enable latch
  localparam logic [7:0] OPC_SECTOR_OPEN = 8'h26; // Opens one sector
  localparam logic [7:0] OPC_SECTOR_CLOSE = 8'h24; // Closes the open sector

  // ****************************************
  // Frame geometry
  // ****************************************
  localparam int unsigned OPC_CLOCKS = 8; // Opcode clocks
  localparam int unsigned ADDR_CLOCKS = 24; // Address clocks
  localparam int unsigned FRAME_W = 32; // Shift register width
  localparam int unsigned BIT_CNT_W = 6; // Clock counter width
  localparam logic [5:0] BIT_CNT_MAX = 6'h3F; // Counter saturates here
  localparam logic [5:0] SHORT_FRAME_BITS = 6'h08; // One opcode byte
  localparam logic [5:0] OPEN_FRAME_BITS = 6'h20; // Opcode plus address

  // ****************************************
  // Address fields
  // ****************************************
  localparam int unsigned ADDR_W = 24; // Address width
  localparam int unsigned SECTOR_LSB = 12; // A0..A11 not decoded
  localparam int unsigned BLOCK_LSB = 16; // 64 KB blocks
  localparam int unsigned BLOCK_MSB = 21; // Top decoded bit
  localparam int unsigned SECTOR_W = 10; // Sector number width
  localparam int unsigned BLOCK_W = 6; // Block number width
  localparam logic [6:0] BLOCK_COUNT = 7'h40; // Blocks in the array
  localparam logic [3:0] BP_ALL = 4'h7; // This code and above protect all

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned REF_CLK_HZ = 50_000_000; // Reference clock rate
  localparam int unsigned PUW_MAX_MS = 10; // Power-up write delay, ms
  localparam int unsigned PUW_CYCLES = PUW_MAX_MS * (REF_CLK_HZ / 1000);
  localparam int unsigned PUW_CNT_W = 20; // Delay counter width

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    SFG_PWR_WAIT = 2'b00, // Power-up delay running
    SFG_PWR_STANDBY = 2'b01 // Accepting instructions
  } sfg_pwr_t;

  typedef struct packed {
    logic [BIT_CNT_W-1:0] bit_cnt; // Clocks seen in this frame
    logic [FRAME_W-1:0] shift; // Last bits shifted in
  } sfg_link_t;

  typedef struct packed {
    sfg_pwr_t pwr; // Power state
    logic [PUW_CNT_W-1:0] puw_cnt; // Power-up delay counter
    logic cs_s1; // Select synchroniser
    logic cs_s2;
    logic cs_s3; // Edge history
    logic low_s1; // Supply-low synchroniser
    logic low_s2;
    logic write_enable_latch; // Write enable latch
    logic sector_open; // One sector is open
    logic [SECTOR_W-1:0] open_sector; // Which one
    logic pgm_allowed; // Answer to the address check
  } sfg_state_t;

endpackage

// ---- dv/sfg_guard_tb.sv ----
// Self-checking bench of the sector unlock guard.
// Assumes sfg_host on the serial pins and PUW_CYCLES of 20.
`timescale 1ns/10ps
module sfg_guard_tb;
  // ****************************************
  // Signals, scoreboard and reference state
  // ****************************************
  logic clk, rst_n, sck, cs_n, si, vcc_low, chk;
  logic [3:0] bp;
  logic [23:0] addr;
  logic ready, inh, latch, sopen, pgm;
  logic [9:0] sec;
  logic [14:0] exp_q[$]; // Expected results, oldest first
  logic [14:0] e;
  int bad_count, checked;
  int seed = 32'h7F7E4AA7;
  bit m_rdy, m_inh, m_latch, m_open; // Reference state
  logic [9:0] m_sec;

  sfg_guard #(.PUW_CYCLES(20)) uut (.REF_CLK_IN(clk), .RST_N_IN(rst_n), .SCK_IN(sck),
    .CS_N_IN(cs_n), .SI_IN(si), .VCC_LOW_IN(vcc_low), .BLOCK_PROTECT_IN(bp),
    .CHECK_ADDR_IN(addr), .READY_OUT(ready), .WRITE_INHIBIT_OUT(inh),
    .WRITE_ENABLE_LATCH_OUT(latch), .SECTOR_OPEN_OUT(sopen), .OPEN_SECTOR_OUT(sec),
    .PGM_ALLOWED_OUT(pgm));
  sfg_host host (.sck_out(sck), .cs_n_out(cs_n), .si_out(si));

  // Reference clock, 20 ns
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input logic [14:0] seen, input logic [14:0] want);
    checked++;
    if (seen !== want)
    begin
      bad_count++;
      $display("FAIL %0t seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Protected block under the current protect code
  function automatic bit prot(input logic [5:0] b);
    if (bp == 4'h0)
      return 1'b0;
    if (bp >= 4'h7)
      return 1'b1;
    return int'(b) >= 64 - (1 << (bp - 4'h1));
  endfunction

  // Frame on the link, then reference update
  task automatic frame(input int n, input logic [32:0] d);
    host.send(n, d);
    if (m_rdy)
    begin
      if (n == 8 && d[7:0] == sfg_pkg::OPC_WRITE_ENABLE && !m_inh)
        m_latch = 1'b1;
      if (n == 8 && d[7:0] == sfg_pkg::OPC_SECTOR_CLOSE)
        m_open = 1'b0;
      if (n == 32 && d[31:24] == sfg_pkg::OPC_SECTOR_OPEN && m_latch && !m_inh && !m_open && prot(d[21:16]))
      begin
        m_open = 1'b1;
        m_sec = d[21:12];
        m_latch = 1'b0;
      end
    end
    repeat (6) @(posedge clk);
  endtask

  // Ask about one address and note the expected outputs
  task automatic note(input logic [23:0] a);
    addr <= a;
    repeat (2) @(posedge clk);
    exp_q.push_back({m_rdy, m_inh, m_latch, m_open, m_sec,
      m_rdy & !m_inh & (!prot(a[21:16]) | (m_open & (m_sec == a[21:12])))});
    chk <= 1'b1;
    @(posedge clk);
    chk <= 1'b0;
  endtask

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    {m_rdy, m_latch, m_open} = 3'h0;
    m_sec = 10'h000;
  endtask

  // ****************************************
  // Monitor: compares against the oldest note
  // ****************************************
  always @(negedge clk)
    if (chk)
    begin
      e = exp_q.pop_front();
      check({13'h0, ready, inh}, {13'h0, e[14:13]});
      check({14'h0, latch}, {14'h0, e[12]});
      check({3'h0, sopen, sec, pgm}, {3'h0, e[11:0]});
    end

  // Watchdog
  initial
  begin
    #100us;
    bad_count++;
    finish_test();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    logic [23:0] a;
    rst_n = 1'b0;
    vcc_low = 1'b0;
    chk = 1'b0;
    bp = 4'h0;
    addr = 24'h000000;
    do_reset();
    frame(8, sfg_pkg::OPC_WRITE_ENABLE);
    note(24'($random(seed)));
    repeat (12) @(posedge clk);
    m_rdy = 1'b1;
    note(24'($random(seed)));
    a = 24'($random(seed)) | 24'h3F0000;
    frame(8, sfg_pkg::OPC_WRITE_ENABLE);
    frame(32, {sfg_pkg::OPC_SECTOR_OPEN, a});
    note(a);
    bp <= 4'h7;
    frame(31, {sfg_pkg::OPC_SECTOR_OPEN, a});
    frame(33, {sfg_pkg::OPC_SECTOR_OPEN, a});
    note(a);
    frame(32, {sfg_pkg::OPC_SECTOR_OPEN, a});
    note(a ^ 24'h000FFF);
    note(a ^ 24'h001000);
    frame(8, sfg_pkg::OPC_WRITE_ENABLE);
    frame(32, {sfg_pkg::OPC_SECTOR_OPEN, a ^ 24'h002000});
    note(a ^ 24'h002000);
    frame(8, sfg_pkg::OPC_SECTOR_CLOSE);
    note(a);
    for (int k = 0; k < 16; k++)
    begin
      bp <= 4'(k);
      note(24'($random(seed)));
      note({2'h0, 6'h3F - 6'(k), 16'($random(seed))});
    end
    bp <= 4'h7;
    frame(8, sfg_pkg::OPC_WRITE_ENABLE);
    vcc_low <= 1'b1;
    m_inh = 1'b1;
    m_latch = 1'b0;
    repeat (4) @(posedge clk);
    note(a);
    frame(8, sfg_pkg::OPC_WRITE_ENABLE);
    note(a);
    vcc_low <= 1'b0;
    m_inh = 1'b0;
    repeat (4) @(posedge clk);
    // Latch was cleared by the inhibit: an open now must be refused
    frame(32, {sfg_pkg::OPC_SECTOR_OPEN, a});
    note(a);
    frame(8, sfg_pkg::OPC_WRITE_ENABLE);
    frame(32, {sfg_pkg::OPC_SECTOR_OPEN, a});
    note(a);
    do_reset();
    repeat (25) @(posedge clk);
    m_rdy = 1'b1;
    note(a);
    finish_test();
  end
endmodule // sfg_guard_tb

// ---- dv/sfg_host.sv ----
// SPI host model for the sector unlock guard bench.
// Assumes the caller spaces frames by at least 100 ns.
`timescale 1ns/10ps
module sfg_host (
  output logic sck_out, // Serial clock, still outside frames
  output logic cs_n_out, // Chip select, active low
  output logic si_out // Serial data, MSB first
);
  // ****************************************
  // Idle levels
  // ****************************************
  initial
  begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    si_out = 1'b0;
  end

  // ****************************************
  // One frame of n clocks at 12 ns, low n bits of d
  // ****************************************
  task automatic send(input int n, input logic [32:0] d);
    // Select falls a little after the caller's clock edge, never on it
    #3 cs_n_out = 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      si_out = d[i];
      #6 sck_out = 1'b1;
      #6 sck_out = 1'b0;
    end
    #6 cs_n_out = 1'b1;
    si_out = ~si_out; // Released line shows no stale bit
  endtask
endmodule // sfg_host
